/* File: rtl/pattern_output_data_staging.sv */
`timescale 1ns/1ns

// Summary of operation
// - each port has an 8-bit write-only direction register, one bit per pin
// - port A data holds groups 0,1; enabled bits ignore software writes
// - port B data holds groups 2,3; enabled bits ignore software writes
// - selected trigger of group 0 or 1 copies staged A bits to port A
// - next data A clears on reset and hardware standby, kept otherwise
// - shared trigger 0/1: next data A is one byte at main location
// - shared trigger 0/1: alternate A location ignores writes, reads ones
// - split trigger 0/1: group 1 nibble at main, group 0 nibble at alt
// - split trigger 0/1: unused nibbles unwritable and read as ones
// - selected trigger of group 2 or 3 copies staged B bits to port B
// - next data B clears on reset and hardware standby, kept otherwise
// - shared trigger 2/3: next data B is one byte at main location
// - shared trigger 2/3: alternate B location ignores writes, reads ones
// - split trigger 2/3: group 3 at main, group 2 at alt, rest ones
// - bits with enable clear are never copied on a trigger
// - 2-bit trigger field per group picks timer channel, reset channel 3
module pattern_output_data_staging #(
  parameter int PORT_W = 8
) (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic [1:0]       hresp,
  output logic [31:0]      hrdata,
  input  wire logic [3:0]  compare_match,
  input  wire logic        hw_standby,
  output logic [7:0]       port_a_pin_out,
  output logic [7:0]       port_a_pin_oe,
  output logic [7:0]       port_b_pin_out,
  output logic [7:0]       port_b_pin_oe
);

  // ----------------------------------------------------------------
  // elaboration check
  // ----------------------------------------------------------------
  if (PORT_W != 8) begin : g_bad_width
    $error("port width other than 8 is not supported");
  end

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [7:0]  next_data_a;
  logic [7:0]  next_data_b;
  logic [7:0]  next_enable_a;
  logic [7:0]  next_enable_b;
  logic [7:0]  trigger_select_control;
  logic        d_valid;
  logic        d_write;
  logic [15:0] d_idx;
  logic        rd_wait;

  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  wire logic addr_take = hsel && hready && htrans[1];
  wire logic wr_act    = d_valid && d_write;
  wire logic rd_load   = d_valid && !d_write && rd_wait;
  wire logic [7:0] wd  = hwdata[7:0];

  wire logic wr_dir_a  = wr_act &&
                         (d_idx == pattern_output_pkg::IDX_PORT_A_DIRECTION);
  wire logic wr_dir_b  = wr_act &&
                         (d_idx == pattern_output_pkg::IDX_PORT_B_DIRECTION);
  wire logic wr_port_a = wr_act &&
                         (d_idx == pattern_output_pkg::IDX_PORT_A_OUTPUT_DATA);
  wire logic wr_port_b = wr_act &&
                         (d_idx == pattern_output_pkg::IDX_PORT_B_OUTPUT_DATA);
  wire logic wr_en_a   = wr_act &&
                         (d_idx == pattern_output_pkg::IDX_NEXT_ENABLE_A);
  wire logic wr_en_b   = wr_act &&
                         (d_idx == pattern_output_pkg::IDX_NEXT_ENABLE_B);
  wire logic wr_tsel   = wr_act &&
                         (d_idx == pattern_output_pkg::IDX_TRIGGER_SELECT);
  wire logic wr_nda_m  = wr_act &&
                         (d_idx == pattern_output_pkg::IDX_NEXT_DATA_A_MAIN);
  wire logic wr_nda_x  = wr_act &&
                         (d_idx == pattern_output_pkg::IDX_NEXT_DATA_A_ALT);
  wire logic wr_ndb_m  = wr_act &&
                         (d_idx == pattern_output_pkg::IDX_NEXT_DATA_B_MAIN);
  wire logic wr_ndb_x  = wr_act &&
                         (d_idx == pattern_output_pkg::IDX_NEXT_DATA_B_ALT);

  // ----------------------------------------------------------------
  // triggers: one select field and one fire strobe per group
  // ----------------------------------------------------------------
  wire logic [3:0] fire;
  logic [1:0] tsel [4];

  for (genvar g = 0; g < pattern_output_pkg::GROUP_COUNT; g++) begin : g_grp
    assign tsel[g] = trigger_select_control[g*2 +: 2];
    assign fire[g] = compare_match[tsel[g]];
  end

  // pairs share addressing when their codes match
  wire logic shared_a = (tsel[0] == tsel[1]);
  wire logic shared_b = (tsel[2] == tsel[3]);

  // bits that a trigger moves this cycle; disabled bits never move
  wire logic [7:0] fire_mask_a = {{4{fire[1]}}, {4{fire[0]}}}
                                 & next_enable_a;
  wire logic [7:0] fire_mask_b = {{4{fire[3]}}, {4{fire[2]}}}
                                 & next_enable_b;

  // ----------------------------------------------------------------
  // port data next values
  // ----------------------------------------------------------------
  // software only reaches bits not claimed by pattern output
  wire logic [7:0] sw_port_a = wr_port_a ?
      ((wd & ~next_enable_a) | (port_a_pin_out & next_enable_a)) :
      port_a_pin_out;
  wire logic [7:0] sw_port_b = wr_port_b ?
      ((wd & ~next_enable_b) | (port_b_pin_out & next_enable_b)) :
      port_b_pin_out;
  // trigger bits are a subset of enabled bits, so no clash with software
  wire logic [7:0] next_port_a = (sw_port_a & ~fire_mask_a)
                                 | (next_data_a & fire_mask_a);
  wire logic [7:0] next_port_b = (sw_port_b & ~fire_mask_b)
                                 | (next_data_b & fire_mask_b);

  // ----------------------------------------------------------------
  // staging register next values
  // ----------------------------------------------------------------
  // shared: whole byte at main; split: upper at main, lower at alt
  wire logic [7:0] next_nda =
      (wr_nda_m && shared_a)  ? wd :
      (wr_nda_m && !shared_a) ? {wd[7:4], next_data_a[3:0]} :
      (wr_nda_x && !shared_a) ? {next_data_a[7:4], wd[3:0]} :
      next_data_a;
  wire logic [7:0] next_ndb =
      (wr_ndb_m && shared_b)  ? wd :
      (wr_ndb_m && !shared_b) ? {wd[7:4], next_data_b[3:0]} :
      (wr_ndb_x && !shared_b) ? {next_data_b[7:4], wd[3:0]} :
      next_data_b;

  // ----------------------------------------------------------------
  // read mux
  // ----------------------------------------------------------------
  // reserved nibbles read as ones in whichever view is active
  wire logic [7:0] rd_nda_m = shared_a ? next_data_a :
      {next_data_a[7:4], pattern_output_pkg::RESERVED_NIBBLE};
  wire logic [7:0] rd_nda_x = shared_a ? pattern_output_pkg::RESERVED_BYTE :
      {pattern_output_pkg::RESERVED_NIBBLE, next_data_a[3:0]};
  wire logic [7:0] rd_ndb_m = shared_b ? next_data_b :
      {next_data_b[7:4], pattern_output_pkg::RESERVED_NIBBLE};
  wire logic [7:0] rd_ndb_x = shared_b ? pattern_output_pkg::RESERVED_BYTE :
      {pattern_output_pkg::RESERVED_NIBBLE, next_data_b[3:0]};

  logic [7:0] rd_byte;
  logic       rd_hit;

  // direction registers are write-only and read as zero
  always_comb begin
    rd_hit  = 1'b1;
    rd_byte = pattern_output_pkg::RST_ZERO_BYTE;
    case (d_idx)
      pattern_output_pkg::IDX_PORT_A_OUTPUT_DATA: rd_byte = port_a_pin_out;
      pattern_output_pkg::IDX_PORT_B_OUTPUT_DATA: rd_byte = port_b_pin_out;
      pattern_output_pkg::IDX_NEXT_ENABLE_A:    rd_byte = next_enable_a;
      pattern_output_pkg::IDX_NEXT_ENABLE_B:    rd_byte = next_enable_b;
      pattern_output_pkg::IDX_TRIGGER_SELECT:   rd_byte = trigger_select_control;
      pattern_output_pkg::IDX_NEXT_DATA_A_MAIN: rd_byte = rd_nda_m;
      pattern_output_pkg::IDX_NEXT_DATA_A_ALT:  rd_byte = rd_nda_x;
      pattern_output_pkg::IDX_NEXT_DATA_B_MAIN: rd_byte = rd_ndb_m;
      pattern_output_pkg::IDX_NEXT_DATA_B_ALT:  rd_byte = rd_ndb_x;
      default:                                  rd_hit  = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------
  // bus phase tracking
  // ----------------------------------------------------------------
  // reads take one wait state so a write just before is seen
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      d_valid   <= 1'b0;
      d_write   <= 1'b0;
      d_idx     <= 16'h0000;
      rd_wait   <= 1'b0;
      hreadyout <= 1'b1;
      hresp     <= pattern_output_pkg::HRESP_OKAY;
      hrdata    <= pattern_output_pkg::READ_NONE;
    end else if (rd_load) begin
      d_valid   <= 1'b0;
      rd_wait   <= 1'b0;
      hreadyout <= 1'b1;
      hrdata    <= rd_hit ? {24'h000000, rd_byte} :
                   pattern_output_pkg::READ_NONE;
    end else if (hready) begin
      d_valid   <= addr_take;
      d_write   <= hwrite;
      d_idx     <= haddr[pattern_output_pkg::HADDR_IDX_LSB +: 16];
      rd_wait   <= addr_take && !hwrite;
      hreadyout <= !(addr_take && !hwrite);
    end
  end

  // ----------------------------------------------------------------
  // configuration registers
  // ----------------------------------------------------------------
  // hardware standby clears like reset; software standby keeps all
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      port_a_pin_oe          <= pattern_output_pkg::RST_ZERO_BYTE;
      port_b_pin_oe          <= pattern_output_pkg::RST_ZERO_BYTE;
      next_enable_a          <= pattern_output_pkg::RST_ZERO_BYTE;
      next_enable_b          <= pattern_output_pkg::RST_ZERO_BYTE;
      trigger_select_control <= pattern_output_pkg::RST_TRIGGER_SELECT;
    end else if (hw_standby) begin
      port_a_pin_oe          <= pattern_output_pkg::RST_ZERO_BYTE;
      port_b_pin_oe          <= pattern_output_pkg::RST_ZERO_BYTE;
      next_enable_a          <= pattern_output_pkg::RST_ZERO_BYTE;
      next_enable_b          <= pattern_output_pkg::RST_ZERO_BYTE;
      trigger_select_control <= pattern_output_pkg::RST_TRIGGER_SELECT;
    end else begin
      if (wr_dir_a) port_a_pin_oe <= wd;
      if (wr_dir_b) port_b_pin_oe <= wd;
      if (wr_en_a)  next_enable_a <= wd;
      if (wr_en_b)  next_enable_b <= wd;
      if (wr_tsel)  trigger_select_control <= wd;
    end
  end

  // ----------------------------------------------------------------
  // port data and staging registers
  // ----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      port_a_pin_out <= pattern_output_pkg::RST_ZERO_BYTE;
      port_b_pin_out <= pattern_output_pkg::RST_ZERO_BYTE;
      next_data_a    <= pattern_output_pkg::RST_ZERO_BYTE;
      next_data_b    <= pattern_output_pkg::RST_ZERO_BYTE;
    end else if (hw_standby) begin
      port_a_pin_out <= pattern_output_pkg::RST_ZERO_BYTE;
      port_b_pin_out <= pattern_output_pkg::RST_ZERO_BYTE;
      next_data_a    <= pattern_output_pkg::RST_ZERO_BYTE;
      next_data_b    <= pattern_output_pkg::RST_ZERO_BYTE;
    end else begin
      port_a_pin_out <= next_port_a;
      port_b_pin_out <= next_port_b;
      next_data_a    <= next_nda;
      next_data_b    <= next_ndb;
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  property p_dir_write;
    wr_dir_a && !hw_standby |=> port_a_pin_oe == $past(hwdata[7:0]);
  endproperty
  a_dir_write: assert property (p_dir_write)
    else $error("direction write not stored");

  property p_port_a_locked;
    wr_port_a && fire_mask_a == 8'h00 && !hw_standby |=>
      ((port_a_pin_out ^ $past(port_a_pin_out))
       & $past(next_enable_a)) == 8'h00;
  endproperty
  a_port_a_locked: assert property (p_port_a_locked)
    else $error("enabled port A bit changed by software");

  property p_port_b_locked;
    wr_port_b && fire_mask_b == 8'h00 && !hw_standby |=>
      ((port_b_pin_out ^ $past(port_b_pin_out))
       & $past(next_enable_b)) == 8'h00;
  endproperty
  a_port_b_locked: assert property (p_port_b_locked)
    else $error("enabled port B bit changed by software");

  property p_copy_a;
    fire_mask_a != 8'h00 && !hw_standby |=>
      (port_a_pin_out & $past(fire_mask_a))
      == ($past(next_data_a) & $past(fire_mask_a));
  endproperty
  a_copy_a: assert property (p_copy_a)
    else $error("staged A bits not copied on trigger");

  property p_copy_b;
    fire_mask_b != 8'h00 && !hw_standby |=>
      (port_b_pin_out & $past(fire_mask_b))
      == ($past(next_data_b) & $past(fire_mask_b));
  endproperty
  a_copy_b: assert property (p_copy_b)
    else $error("staged B bits not copied on trigger");

  property p_hold_a;
    fire_mask_a == 8'h00 && !wr_port_a && !hw_standby |=>
      $stable(port_a_pin_out);
  endproperty
  a_hold_a: assert property (p_hold_a)
    else $error("port A changed without trigger or write");

  property p_standby_clear;
    hw_standby |=> next_data_a == 8'h00 && next_data_b == 8'h00;
  endproperty
  a_standby_clear: assert property (p_standby_clear)
    else $error("staging not cleared in hardware standby");

  property p_alt_a_shared;
    rd_load && shared_a &&
      d_idx == pattern_output_pkg::IDX_NEXT_DATA_A_ALT |=>
      hrdata == 32'h000000ff && hreadyout;
  endproperty
  a_alt_a_shared: assert property (p_alt_a_shared)
    else $error("reserved A location did not read as ones");

  property p_main_a_split;
    rd_load && !shared_a &&
      d_idx == pattern_output_pkg::IDX_NEXT_DATA_A_MAIN |=>
      hrdata[3:0] == 4'hf;
  endproperty
  a_main_a_split: assert property (p_main_a_split)
    else $error("unused A nibble did not read as ones");

  property p_main_b_shared;
    wr_ndb_m && shared_b && !hw_standby |=>
      next_data_b == $past(hwdata[7:0]);
  endproperty
  a_main_b_shared: assert property (p_main_b_shared)
    else $error("shared B byte write not stored");

  property p_read_answer;
    addr_take && !hwrite |=> !hreadyout ##1 hreadyout;
  endproperty
  a_read_answer: assert property (p_read_answer)
    else $error("read did not answer after one wait state");

endmodule : pattern_output_data_staging

/* File: rtl/pattern_output_pkg.sv */
package pattern_output_pkg;

  // ----------------------------------------------------------------
  // register indices (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [15:0] IDX_TRIGGER_SELECT = 16'hffa1;
  localparam logic [15:0] IDX_NEXT_ENABLE_B  = 16'hffa2;
  localparam logic [15:0] IDX_NEXT_ENABLE_A  = 16'hffa3;
  localparam logic [15:0] IDX_NEXT_DATA_B_MAIN = 16'hffa4;
  localparam logic [15:0] IDX_NEXT_DATA_A_MAIN = 16'hffa5;
  localparam logic [15:0] IDX_NEXT_DATA_B_ALT  = 16'hffa6;
  localparam logic [15:0] IDX_NEXT_DATA_A_ALT  = 16'hffa7;
  localparam logic [15:0] IDX_PORT_A_DIRECTION = 16'hffd1;
  localparam logic [15:0] IDX_PORT_A_OUTPUT_DATA = 16'hffd3;
  localparam logic [15:0] IDX_PORT_B_DIRECTION = 16'hffd4;
  localparam logic [15:0] IDX_PORT_B_OUTPUT_DATA = 16'hffd6;

  // ----------------------------------------------------------------
  // field layout
  // ----------------------------------------------------------------
  localparam int GROUP_COUNT   = 4;
  localparam int TSEL_W        = 2;  // bits per group trigger field
  localparam int NIBBLE_W      = 4;
  localparam int UPPER_LSB     = 4;  // odd group of a pair sits here
  localparam int HADDR_IDX_LSB = 2;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_TRIGGER_SELECT = 8'hff;  // channel 3 each
  localparam logic [7:0] RST_ZERO_BYTE      = 8'h00;
  localparam logic [7:0] RESERVED_BYTE      = 8'hff;
  localparam logic [3:0] RESERVED_NIBBLE    = 4'hf;
  localparam logic [31:0] READ_NONE         = 32'h00000000;

  // ----------------------------------------------------------------
  // bus encodings
  // ----------------------------------------------------------------
  localparam logic [1:0] HRESP_OKAY = 2'h0;

endpackage : pattern_output_pkg

/* File: verif/compare_match_source.sv */
`timescale 1ns/1ns

// ----------------------------------------------------------------
// timer compare-match strobe source
// ----------------------------------------------------------------
module compare_match_source (
  input  wire logic       hclk,
  input  wire logic       hresetn,
  input  wire logic       req,
  input  wire logic [1:0] ch,
  input  wire logic       slow,
  output logic [3:0]      compare_match
);
  logic       armed;
  logic [1:0] held_ch;
  logic [1:0] wait_cnt;

  // a slow channel matches a few cycles after the request; the strobe
  // is one cycle wide and drops back to 0, as a real match does
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      armed         <= 1'b0;
      held_ch       <= 2'h0;
      wait_cnt      <= 2'h0;
      compare_match <= 4'h0;
    end else begin
      compare_match <= 4'h0;
      if (req) begin
        armed    <= 1'b1;
        held_ch  <= ch;
        wait_cnt <= slow ? 2'h3 : 2'h0;
      end else if (armed && wait_cnt != 2'h0) begin
        wait_cnt <= wait_cnt - 2'h1;
      end else if (armed) begin
        armed                  <= 1'b0;
        compare_match[held_ch] <= 1'b1;
      end
    end
  end
endmodule : compare_match_source

/* File: verif/tb_pattern_output_data_staging.sv */
`timescale 1ns/1ns

module tb_pattern_output_data_staging;
  localparam logic [15:0] TRIG = pattern_output_pkg::IDX_TRIGGER_SELECT;
  localparam logic [15:0] EN_A = pattern_output_pkg::IDX_NEXT_ENABLE_A;
  localparam logic [15:0] EN_B = pattern_output_pkg::IDX_NEXT_ENABLE_B;
  localparam logic [15:0] NA_M = pattern_output_pkg::IDX_NEXT_DATA_A_MAIN;
  localparam logic [15:0] NA_L = pattern_output_pkg::IDX_NEXT_DATA_A_ALT;
  localparam logic [15:0] NB_M = pattern_output_pkg::IDX_NEXT_DATA_B_MAIN;
  localparam logic [15:0] NB_L = pattern_output_pkg::IDX_NEXT_DATA_B_ALT;
  localparam logic [15:0] DIRA = pattern_output_pkg::IDX_PORT_A_DIRECTION;
  localparam logic [15:0] DIRB = pattern_output_pkg::IDX_PORT_B_DIRECTION;
  localparam logic [15:0] PA_D = pattern_output_pkg::IDX_PORT_A_OUTPUT_DATA;
  localparam logic [15:0] PB_D = pattern_output_pkg::IDX_PORT_B_OUTPUT_DATA;

  logic        hclk, hresetn, hsel, hwrite, hreadyout, hw_standby;
  logic        req, slow, rd_pend;
  logic [1:0]  htrans, hresp, ch;
  logic [2:0]  hsize;
  logic [31:0] haddr, hwdata, hrdata;
  logic [3:0]  compare_match;
  logic [7:0]  pa_out, pa_oe, pb_out, pb_oe, r, pb;
  logic [7:0]  exp_q[$];
  int          n_fail, n_tests, seed, i;

  pattern_output_data_staging u_dut (.hclk(hclk), .hresetn(hresetn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .compare_match(compare_match), .hw_standby(hw_standby),
    .port_a_pin_out(pa_out), .port_a_pin_oe(pa_oe),
    .port_b_pin_out(pb_out), .port_b_pin_oe(pb_oe));

  compare_match_source u_timer (.hclk(hclk), .hresetn(hresetn), .req(req),
    .ch(ch), .slow(slow), .compare_match(compare_match));

  initial begin
    hclk = 1'b0;
    forever #10 hclk = ~hclk;
  end

  // generous: the whole sequence needs well under a tenth of this
  initial begin
    #400000;
    n_fail++;
    print_verdict();
  end

  task check(input logic [7:0] seen, input logic [7:0] want, input string s);
    n_tests++;
    if (seen !== want) begin
      n_fail++;
      $display("[FAIL] %0t %s seen %h want %h", $time, s, seen, want);
    end
  endtask : check

  // read data is taken at the edge where the data phase sees ready
  always @(posedge hclk) begin
    if (rd_pend && hreadyout === 1'b1) begin
      rd_pend = 1'b0;
      check(hrdata[7:0], exp_q.pop_front(), "read data");
      // upper data bits stay zero and the response is always okay
      check({|hrdata[31:8], 5'h00, hresp}, 8'h00, "resp and upper bits");
    end
    if (hsel && hreadyout && htrans[1] && !hwrite) rd_pend = 1'b1;
  end

  task wait_ready();
    int k;
    k = 0;
    do begin
      @(posedge hclk);
      k++;
    end while (hreadyout !== 1'b1 && k < 20);
    if (k >= 20) begin
      n_fail++;
      print_verdict();
    end
  endtask : wait_ready

  task xfer(input logic [15:0] idx, input logic wr, input logic [7:0] wd);
    hsel   <= 1'b1;
    haddr  <= {14'h0, idx, 2'b00};
    htrans <= 2'b10;
    hwrite <= wr;
    hsize  <= 3'b010;
    wait_ready();
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= {24'h0, wd};
    wait_ready();
  endtask : xfer

  task wr(input logic [15:0] idx, input logic [7:0] d);
    xfer(idx, 1'b1, d);
  endtask : wr

  task rd(input logic [15:0] idx, input logic [7:0] e);
    exp_q.push_back(e);
    xfer(idx, 1'b0, 8'h00);
  endtask : rd

  // the source answers within five edges, the pins one edge later
  task fire(input logic [1:0] c, input logic s);
    req  <= 1'b1;
    ch   <= c;
    slow <= s;
    @(posedge hclk);
    req <= 1'b0;
    repeat (8) @(posedge hclk);
  endtask : fire

  task print_verdict();
    $display("comparisons %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : print_verdict

  initial begin
    {hsel, hwrite, hw_standby, req, slow, rd_pend, hresetn} = 7'h0;
    {htrans, ch, haddr, hwdata} = 68'h0;
    hsize = 3'b010;
    n_fail = 0;
    n_tests = 0;
    seed = 32'hc06d;
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rd(TRIG, 8'hff);
    rd(EN_A, 8'h00);
    rd(EN_B, 8'h00);
    rd(NA_M, 8'h00);
    rd(NB_M, 8'h00);
    rd(NA_L, 8'hff);
    rd(NB_L, 8'hff);
    rd(PA_D, 8'h00);
    rd(PB_D, 8'h00);
    rd(16'h0123, 8'h00);
    $display("reset values done");
    r = 8'($random(seed));
    wr(DIRA, r);
    wr(DIRB, ~r);
    rd(DIRA, 8'h00);
    check(pa_oe, r, "dir a");
    check(pb_oe, ~r, "dir b");
    wr(DIRA, 8'hff);
    wr(DIRB, 8'hff);
    $display("direction done");
    r = 8'($random(seed));
    wr(NA_M, r);
    rd(NA_M, r);
    wr(NA_L, 8'h00);
    rd(NA_L, 8'hff);
    wr(EN_A, 8'hff);
    fire(2'd3, 1'b0);
    check(pa_out, r, "shared a");
    wr(PA_D, ~r);
    rd(PA_D, r);
    wr(EN_A, 8'h00);
    wr(PA_D, 8'h5a);
    wr(NA_M, 8'ha5);
    wr(EN_A, 8'h0f);
    fire(2'd3, 1'b1);
    check(pa_out, 8'h55, "partial");
    wr(PA_D, 8'h00);
    rd(PA_D, 8'h05);
    $display("shared a done");
    // group 0 on channel 0, group 1 on channel 1
    wr(TRIG, 8'hf4);
    wr(NA_M, 8'hab);
    rd(NA_M, 8'haf);
    wr(NA_L, 8'hcd);
    rd(NA_L, 8'hfd);
    wr(EN_A, 8'hff);
    fire(2'd0, 1'b0);
    check(pa_out, 8'h0d, "split g0");
    fire(2'd1, 1'b1);
    check(pa_out, 8'had, "split g1");
    $display("split a done");
    wr(EN_B, 8'hff);
    pb = 8'h00;
    for (i = 0; i < 4; i++) begin
      r = 8'($random(seed));
      wr(TRIG, {i[1:0], i[1:0], 4'h4});
      wr(NB_M, r);
      rd(NB_L, 8'hff);
      fire(2'(i + 1), 1'b0);
      check(pb_out, pb, "other channel");
      fire(i[1:0], i[0]);
      pb = r;
      check(pb_out, pb, "channel code");
    end
    $display("trigger codes done");
    wr(TRIG, 8'h44);
    wr(NB_M, 8'h3c);
    rd(NB_M, 8'h3f);
    wr(NB_L, 8'h96);
    rd(NB_L, 8'hf6);
    fire(2'd0, 1'b1);
    pb = {pb[7:4], 4'h6};
    check(pb_out, pb, "split g2");
    wr(PB_D, ~pb);
    rd(PB_D, pb);
    $display("split b done");
    hw_standby <= 1'b1;
    @(posedge hclk);
    hw_standby <= 1'b0;
    @(posedge hclk);
    rd(NA_M, 8'h00);
    rd(NB_M, 8'h00);
    rd(TRIG, 8'hff);
    check(pa_out, 8'h00, "standby");
    check(pa_oe, 8'h00, "standby dir");
    $display("standby done");
    // let the last queued read be compared before the verdict
    repeat (2) @(posedge hclk);
    check(8'(exp_q.size()), 8'h00, "reads left");
    print_verdict();
  end
endmodule : tb_pattern_output_data_staging
